// *** scg_pkg.sv ***
// Overview of operation
// - a set gate bit clocks its peripheral; a clear bit stops and disables it
// - any access to a peripheral whose clock is stopped is answered with a fault
// - after reset every gate bit is zero, so all peripherals start unclocked
// - the register resets to all zeros; implemented gate bits are read/write
// - the register is decoded at offset 0x114 from the control block base
// - sleep values govern clocks only in sleep; running uses its own register
// - sleep values apply only while the automatic gating enable is set
// - bit 25 gates comparator one, bit 24 gates comparator zero
// - bits 19 to 16 gate general-purpose counters three, two, one, zero
// - bit 14 gates the second two-wire unit, bit 12 the first
// - bit 5 gates sync serial unit one, bit 4 sync serial unit zero
// - reserved bits read zero and ignore writes; software preserves them
// - bit 1 gates async serial port one, bit 0 async serial port zero
package scg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // memory map
    localparam logic [31:0] SCG_BASE = 32'h400f_e000;
    localparam logic [11:0] SCG_OFF_CLK_CFG = 12'h060;
    localparam logic [11:0] SCG_OFF_RUN_GATE = 12'h104;
    localparam logic [11:0] SCG_OFF_SLEEP_GATE = 12'h114;
    localparam logic [11:0] SCG_OFF_INT_STATUS = 12'h200;
    localparam logic [11:0] SCG_OFF_INT_MASK = 12'h204;

    // auto gating enable position inside the run clock config register
    localparam int SCG_AUTO_GATE_BIT = 27;

    // implemented gate bits; everything else is reserved, reads zero
    localparam logic [31:0] SCG_GATE_MASK = 32'h030f_5033;
    localparam logic [31:0] SCG_RESET_VAL = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // gate layout, shared by run, sleep, status and mask registers
    typedef struct packed {
        logic [5:0] rsvd_31_26;
        logic comparator_one_gate;
        logic comparator_zero_gate;
        logic [3:0] rsvd_23_20;
        logic gp_counter_three_gate;
        logic gp_counter_two_gate;
        logic gp_counter_one_gate;
        logic gp_counter_zero_gate;
        logic rsvd_15;
        logic twowire_one_gate;
        logic rsvd_13;
        logic twowire_zero_gate;
        logic [5:0] rsvd_11_6;
        logic sync_serial_one_gate;
        logic sync_serial_zero_gate;
        logic [1:0] rsvd_3_2;
        logic async_serial_one_gate;
        logic async_serial_zero_gate;
    } scg_gate_t;

    // run clock configuration register contents
    typedef struct packed {
        logic auto_gating_enable;
    } scg_clk_cfg_t;

endpackage

// *** scg_gate_unit.sv ***
`timescale 1ns/1ps
// per-peripheral clock enable selection and gated-access fault detection
module scg_gate_unit
    import scg_pkg::*;
#(
    parameter int N = 32,
    parameter logic [N-1:0] IMPL = SCG_GATE_MASK
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sleep_sel,
    input wire logic [N-1:0] sleep_gate,
    input wire logic [N-1:0] run_gate,
    input wire logic [N-1:0] periph_req,
    output logic [N-1:0] clk_en_q,
    output logic [N-1:0] fault_q
);
    import scg_pkg::*;

    logic [N-1:0] en_d;
    logic [N-1:0] flt_d;

    ////////////////////////////////////////////////////////////////////////
    // one slice per gate bit; reserved slices hold constant zero
    // a single register process keeps one driver per output vector
    for (genvar i = 0; i < N; i++) begin : g_bit
        if (IMPL[i]) begin : g_impl
            // pick the sleep or run setting for this peripheral
            assign en_d[i] = sleep_sel ? sleep_gate[i] : run_gate[i];
            assign flt_d[i] = periph_req[i] & ~clk_en_q[i];
        end else begin : g_rsvd
            assign en_d[i] = 1'b0;
            assign flt_d[i] = 1'b0;
        end
    end

    // enable is registered so the peripheral sees a clean level
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            clk_en_q <= '0;
            fault_q <= '0;
        end else begin
            clk_en_q <= en_d;
            fault_q <= flt_d;
        end
    end

endmodule // scg_gate_unit

// *** scg_top.sv ***
`timescale 1ns/1ps
// sleep clock gating control with ahb-lite register access
module scg_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic core_sleep,
    input wire logic [31:0] periph_req,
    output logic [31:0] periph_clk_en,
    output logic [31:0] periph_fault,
    output logic irq
);
    import scg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    scg_gate_t sleep_q, sleep_d;
    scg_gate_t run_q, run_d;
    scg_gate_t status_q, status_d;
    scg_gate_t mask_q, mask_d;
    scg_clk_cfg_t cfg_q, cfg_d;
    logic wr_pend_q, wr_pend_d;
    logic [31:0] wr_addr_q, wr_addr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic hreadyout_q;
    logic hresp_q;
    logic irq_q, irq_d;
    logic sleep_sel;
    logic take;
    logic rd_take;
    logic [31:0] clk_en_w;
    logic [31:0] fault_w;

    ////////////////////////////////////////////////////////////////////////
    // bus address phase capture; hsize is ignored, only words are used
    always_comb begin
        take = hsel & htrans[1] & hready;
        rd_take = take & ~hwrite;
        wr_pend_d = take & hwrite;
        wr_addr_d = take ? haddr : wr_addr_q;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes land in the data phase; reserved bits forced to zero
    always_comb begin
        sleep_d = sleep_q;
        run_d = run_q;
        mask_d = mask_q;
        cfg_d = cfg_q;
        if (wr_pend_q) begin
            case (wr_addr_q)
                SCG_BASE + 32'(SCG_OFF_SLEEP_GATE): begin
                    sleep_d = scg_gate_t'(hwdata & SCG_GATE_MASK);
                end
                SCG_BASE + 32'(SCG_OFF_RUN_GATE): begin
                    run_d = scg_gate_t'(hwdata & SCG_GATE_MASK);
                end
                SCG_BASE + 32'(SCG_OFF_INT_MASK): begin
                    mask_d = scg_gate_t'(hwdata & SCG_GATE_MASK);
                end
                SCG_BASE + 32'(SCG_OFF_CLK_CFG): begin
                    cfg_d.auto_gating_enable = hwdata[SCG_AUTO_GATE_BIT];
                end
                default: begin
                    // unmapped writes are dropped, response stays okay
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sleep_q <= scg_gate_t'(SCG_RESET_VAL);
            run_q <= scg_gate_t'(SCG_RESET_VAL);
            mask_q <= scg_gate_t'(SCG_RESET_VAL);
            cfg_q <= '0;
        end else begin
            sleep_q <= sleep_d;
            run_q <= run_d;
            mask_q <= mask_d;
            cfg_q <= cfg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock enable selection and fault detection per peripheral
    // sleep settings only count while the core sleeps and auto gating is on
    assign sleep_sel = core_sleep & cfg_q.auto_gating_enable;

    scg_gate_unit #(
        .N(32),
        .IMPL(SCG_GATE_MASK)
    ) u_gate (
        .clk(clk),
        .reset_n(reset_n),
        .sleep_sel(sleep_sel),
        .sleep_gate(sleep_q),
        .run_gate(run_q),
        .periph_req(periph_req),
        .clk_en_q(clk_en_w),
        .fault_q(fault_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // sticky fault status, read clears; a fault in the clearing cycle wins
    always_comb begin
        status_d = status_q;
        if (rd_take && haddr == SCG_BASE + 32'(SCG_OFF_INT_STATUS)) begin
            status_d = '0;
        end
        status_d = status_d | scg_gate_t'(fault_w);
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_q <= scg_gate_t'(SCG_RESET_VAL);
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data built in the address phase so it stands registered in the
    // data phase; next values forward a write still in flight
    always_comb begin
        hrdata_d = hrdata_q;
        if (rd_take) begin
            case (haddr)
                SCG_BASE + 32'(SCG_OFF_SLEEP_GATE): hrdata_d = sleep_d;
                SCG_BASE + 32'(SCG_OFF_RUN_GATE): hrdata_d = run_d;
                SCG_BASE + 32'(SCG_OFF_INT_STATUS): hrdata_d = status_q;
                SCG_BASE + 32'(SCG_OFF_INT_MASK): hrdata_d = mask_d;
                SCG_BASE + 32'(SCG_OFF_CLK_CFG): begin
                    hrdata_d = 32'h0000_0000;
                    hrdata_d[SCG_AUTO_GATE_BIT] = cfg_d.auto_gating_enable;
                end
                default: hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            hrdata_q <= hrdata_d;
            hreadyout_q <= 1'b1; // zero wait states, never stalls
            hresp_q <= 1'b0; // no error responses from this slave
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; hresp is a constant okay flop
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign periph_clk_en = clk_en_w;
    assign periph_fault = fault_w;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_wr_sleep;
        take && hwrite && haddr == SCG_BASE + 32'(SCG_OFF_SLEEP_GATE);
    endsequence

    sequence s_rd_status;
        rd_take && haddr == SCG_BASE + 32'(SCG_OFF_INT_STATUS);
    endsequence

    sequence s_rd_sleep;
        rd_take && !wr_pend_q &&
        haddr == SCG_BASE + 32'(SCG_OFF_SLEEP_GATE);
    endsequence

    sequence s_wr_run;
        take && hwrite && haddr == SCG_BASE + 32'(SCG_OFF_RUN_GATE);
    endsequence

    sequence s_wr_cfg;
        take && hwrite && haddr == SCG_BASE + 32'(SCG_OFF_CLK_CFG);
    endsequence

    sequence s_wr_mask;
        take && hwrite && haddr == SCG_BASE + 32'(SCG_OFF_INT_MASK);
    endsequence

    sequence s_foreign_rd;
        rd_take && haddr[31:12] != SCG_BASE[31:12];
    endsequence

    sequence s_foreign_wr;
        take && hwrite && haddr[31:12] != SCG_BASE[31:12];
    endsequence

    chk_reset_clear: assert property (
        @(posedge clk) disable iff (1'b0)
        $rose(reset_n) |-> sleep_q == '0 && clk_en_w == '0)
        else $error("gate state not zero after reset");

    chk_sleep_write: assert property (
        s_wr_sleep ##1 1'b1 |=>
        sleep_q == scg_gate_t'($past(hwdata) & SCG_GATE_MASK))
        else $error("sleep gate register write not stored");

    chk_sleep_readback: assert property (
        s_rd_sleep |=> hrdata == 32'($past(sleep_q)))
        else $error("sleep gate readback mismatch");

    chk_reserved_zero: assert property (
        (32'(sleep_q) & ~SCG_GATE_MASK) == '0 &&
        (clk_en_w & ~SCG_GATE_MASK) == '0)
        else $error("reserved gate bit set");

    chk_sleep_follow: assert property (
        (core_sleep && cfg_q.auto_gating_enable) |=>
        clk_en_w == 32'($past(sleep_q)))
        else $error("sleep enables not applied");

    chk_run_follow: assert property (
        !(core_sleep && cfg_q.auto_gating_enable) |=>
        clk_en_w == 32'($past(run_q)))
        else $error("run enables not applied outside sleep");

    chk_fault_gated: assert property (
        ##1 periph_fault == ($past(periph_req & ~clk_en_w) & SCG_GATE_MASK))
        else $error("gated access fault mismatch");

    chk_clocked_ok: assert property (
        (periph_req & clk_en_w) != '0 |=>
        (periph_fault & $past(periph_req & clk_en_w)) == '0)
        else $error("fault raised on clocked peripheral");

    chk_read_clear: assert property (
        s_rd_status ##0 (fault_w == '0) |=> status_q == '0)
        else $error("status not cleared by read");

    chk_irq_level: assert property (
        |(status_q & mask_q) |-> irq)
        else $error("interrupt low with unmasked status");

    chk_irq_low: assert property (
        (status_q & mask_q) == '0 |-> !irq)
        else $error("interrupt high with nothing unmasked");

    chk_ready_high: assert property (
        hreadyout)
        else $error("slave inserted a wait state");

    chk_resp_okay: assert property (
        !hresp)
        else $error("slave answered with an error response");

    chk_run_write: assert property (
        s_wr_run ##1 1'b1 |=>
        run_q == scg_gate_t'($past(hwdata) & SCG_GATE_MASK))
        else $error("run gate register write not stored");

    chk_cfg_write: assert property (
        s_wr_cfg ##1 1'b1 |=>
        cfg_q.auto_gating_enable == $past(hwdata[SCG_AUTO_GATE_BIT]))
        else $error("auto gating enable write not stored");

    chk_mask_write: assert property (
        s_wr_mask ##1 1'b1 |=>
        mask_q == scg_gate_t'($past(hwdata) & SCG_GATE_MASK))
        else $error("interrupt mask write not stored");

    // a status bit may only drop through a read of the status register
    chk_status_sticky: assert property (
        !(rd_take && haddr == SCG_BASE + 32'(SCG_OFF_INT_STATUS)) |=>
        (status_q & $past(status_q)) == $past(status_q))
        else $error("status bit lost without a read");

    chk_fault_capture: assert property (
        fault_w != '0 |=>
        (32'(status_q) & $past(fault_w)) == $past(fault_w))
        else $error("fault not recorded in status");

    chk_reserved_fault: assert property (
        (periph_fault & ~SCG_GATE_MASK) == '0)
        else $error("reserved position raised a fault");

    chk_unmapped_read: assert property (
        s_foreign_rd |=> hrdata == 32'h0000_0000)
        else $error("read outside the block returned data");

    chk_foreign_write: assert property (
        s_foreign_wr ##1 1'b1 |=>
        sleep_q == $past(sleep_q) && run_q == $past(run_q))
        else $error("write outside the block changed a gate");

    // watches reset itself, so the default disable must not apply
    chk_reset_outputs: assert property (
        @(posedge clk) disable iff (1'b0)
        !reset_n |=> clk_en_w == '0 && periph_fault == '0 && !irq)
        else $error("outputs not cleared by reset");

endmodule // scg_top

// *** tb_sleep_clock_gate_control.sv ***
`timescale 1ns/1ps
// self-checking bench: reference model of the gate registers vs the block
module tb_sleep_clock_gate_control;
    import scg_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic [31:0] hrdata;
    logic [31:0] periph_clk_en;
    logic [31:0] periph_fault;
    logic core_sleep = 1'b0;
    logic [31:0] periph_req = 32'h0000_0000;
    int n_mismatch = 0;
    int n_checks = 0;
    // reference copies of what software has written and of the fault status
    logic [31:0] m_run = 32'h0000_0000;
    logic [31:0] m_sleep = 32'h0000_0000;
    logic [31:0] m_mask = 32'h0000_0000;
    logic [31:0] m_stat = 32'h0000_0000;
    logic m_auto = 1'b0;
    logic [31:0] rd;

    ////////////////////////////////////////////////////////////////////////
    // 40 mhz clock
    always #12.5 clk = ~clk;

    // the slave's own hreadyout closes the bus hready loop
    scg_top DUT (
        .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .core_sleep(core_sleep), .periph_req(periph_req),
        .periph_clk_en(periph_clk_en), .periph_fault(periph_fault),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] ra(input logic [11:0] off);
        return SCG_BASE + {20'h0_0000, off};
    endfunction

    // enable the block should present: sleep values only in auto sleep
    function automatic logic [31:0] exp_en();
        return (core_sleep && m_auto) ? m_sleep : m_run;
    endfunction

    // no fixed latency assumed; only the watchdog ends a stuck wait
    task automatic wait_ready();
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
    endtask

    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask

    task automatic rd_cmp(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, rd);
        cmp32(rd, exp);
    endtask

    // register write that also updates the reference copy
    task automatic reg_wr(input logic [11:0] off, input logic [31:0] d);
        bus(1'b1, ra(off), d, rd);
        case (off)
            SCG_OFF_RUN_GATE: m_run = d & SCG_GATE_MASK;
            SCG_OFF_SLEEP_GATE: m_sleep = d & SCG_GATE_MASK;
            SCG_OFF_CLK_CFG: m_auto = d[SCG_AUTO_GATE_BIT];
            SCG_OFF_INT_MASK: m_mask = d & SCG_GATE_MASK;
            default: ;
        endcase
    endtask

    // let enables and irq settle, look off the edge, realign to an edge
    task automatic chk_out();
        repeat (3) @(posedge clk);
        #1;
        cmp32(periph_clk_en, exp_en());
        cmp_bit(irq, |(m_stat & m_mask));
        cmp_bit(hresp, 1'b0);
        @(posedge clk);
    endtask

    // one cycle of access strobes; fault stands for exactly one cycle
    task automatic poke(input logic [31:0] r);
        logic [31:0] f;
        f = r & ~exp_en() & SCG_GATE_MASK;
        periph_req <= r;
        @(posedge clk);
        periph_req <= 32'h0000_0000;
        #1;
        cmp32(periph_fault, f);
        m_stat = m_stat | f;
        @(posedge clk);
        #1;
        cmp32(periph_fault, 32'h0000_0000);
        @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(21));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        // reset state of the sleep, run and mask registers and of the outputs
        rd_cmp(ra(SCG_OFF_SLEEP_GATE), SCG_RESET_VAL);
        rd_cmp(ra(SCG_OFF_RUN_GATE), 32'h0000_0000);
        rd_cmp(ra(SCG_OFF_INT_MASK), 32'h0000_0000);
        chk_out();
        // reserved bits stay zero; near and foreign addresses miss
        reg_wr(SCG_OFF_SLEEP_GATE, 32'hffff_ffff);
        rd_cmp(ra(SCG_OFF_SLEEP_GATE), SCG_GATE_MASK);
        bus(1'b1, ra(12'h118), 32'h0000_0000, rd);
        bus(1'b1, 32'h400f_f114, 32'h0000_0000, rd);
        rd_cmp(ra(SCG_OFF_SLEEP_GATE), SCG_GATE_MASK);
        rd_cmp(32'h400f_f114, 32'h0000_0000);
        // a mid-run reset clears the gates that were just written
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        m_sleep = 32'h0000_0000;
        rd_cmp(ra(SCG_OFF_SLEEP_GATE), SCG_RESET_VAL);
        chk_out();
        // walking one: each bit drives only its own enable in auto sleep
        reg_wr(SCG_OFF_RUN_GATE, 32'h0000_0000);
        reg_wr(SCG_OFF_CLK_CFG, 32'h1 << SCG_AUTO_GATE_BIT);
        core_sleep <= 1'b1;
        for (int b = 0; b < 32; b++) begin
            reg_wr(SCG_OFF_SLEEP_GATE, 32'h1 << b);
            chk_out();
        end
        // random gates across all four sleep/auto combinations
        for (int i = 0; i < 24; i++) begin
            reg_wr(SCG_OFF_RUN_GATE, $urandom());
            reg_wr(SCG_OFF_SLEEP_GATE, $urandom());
            reg_wr(SCG_OFF_CLK_CFG, 32'(i[0]) << SCG_AUTO_GATE_BIT);
            core_sleep <= i[1];
            chk_out();
            rd_cmp(ra(SCG_OFF_RUN_GATE), m_run);
            rd_cmp(ra(SCG_OFF_CLK_CFG), 32'(i[0]) << SCG_AUTO_GATE_BIT);
            poke($urandom());
        end
        // interrupt: a sure fault, masked, unmasked, cleared by a read
        reg_wr(SCG_OFF_INT_MASK, 32'h0000_0000);
        reg_wr(SCG_OFF_RUN_GATE, 32'h0000_0000);
        core_sleep <= 1'b0;
        chk_out();
        poke(32'h0000_0001);
        chk_out();
        reg_wr(SCG_OFF_INT_MASK, SCG_GATE_MASK);
        rd_cmp(ra(SCG_OFF_INT_MASK), m_mask);
        chk_out();
        rd_cmp(ra(SCG_OFF_INT_STATUS), m_stat);
        m_stat = 32'h0000_0000;
        chk_out();
        complete_run();
    end

    // watchdog: run needs about 700 cycles, this allows 20000
    initial begin
        #500000;
        n_mismatch++;
        complete_run();
    end
endmodule // tb_sleep_clock_gate_control
